// *** common/synth_host_pkg.sv ***
// Constants, word layouts and types for the synthesizer serial-load controller
package synth_host_pkg;
	// Serial word geometry
	localparam int         WORD_W         = 24;
	localparam logic [4:0] LEN_FREQ       = 5'h18;
	localparam logic [4:0] LEN_MOD        = 5'h18;
	localparam logic [4:0] LEN_PHASE      = 5'h10;
	localparam logic [4:0] LEN_FUNC       = 5'h10;
	localparam logic [4:0] LEN_TIMER      = 5'h18;
	localparam logic [4:0] LEN_PDOWN      = 5'h08;
	// Three select bits in the low end of every word
	localparam logic [2:0] SEL_FREQ       = 3'h0;
	localparam logic [2:0] SEL_MOD        = 3'h1;
	localparam logic [2:0] SEL_PHASE      = 3'h2;
	localparam logic [2:0] SEL_FUNC       = 3'h3;
	localparam logic [2:0] SEL_TIMER      = 3'h4;
	localparam logic [2:0] SEL_PDOWN      = 3'h5;
	// Fixed field values
	localparam logic       PHASE_RSV_VAL  = 1'b0;
	localparam logic [9:0] FUNC_RSV_VAL   = 10'h001;
	localparam logic       FUNC_RSV4_VAL  = 1'b1;
	localparam logic [9:0] TIMER_RSV_VAL  = 10'h001;
	// Timer select codes and switch margin
	localparam logic [1:0] TSEL_BOOST     = 2'h2;
	localparam logic [1:0] TSEL_SW3       = 2'h1;
	localparam logic [1:0] TSEL_SW12      = 2'h0;
	localparam logic [8:0] SW_MARGIN      = 9'h007;
	localparam logic [8:0] CNT_MAX        = 9'h1FF;
	// Modulus assumed before the first modulus write
	localparam logic [11:0] MOD_RESET     = 12'h00D;
	// Serial clock timing
	localparam int         CLK_PERIOD_NS  = 5;
	localparam int         SCLK_PERIOD_NS = 40;
	localparam int         SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		OP_FREQ   = 3'h0,
		OP_MOD    = 3'h1,
		OP_PHASE  = 3'h2,
		OP_FUNC   = 3'h3,
		OP_TIMERS = 3'h4,
		OP_PDOWN  = 3'h5
	} op_e;

	typedef struct packed {
		op_e         op;
		logic [20:0] data;
	} cmd_s;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SHIFT  = 5'h02,
		ST_REFWT  = 5'h04,
		ST_LATCH  = 5'h08,
		ST_GAP    = 5'h10
	} state_e;
endpackage

// *** design/synth_phase_function_fastlock_regs.sv ***
// Host-side serial loader for the synthesizer configuration registers
`timescale 1ns/10ps
module synth_phase_function_fastlock_regs
	import synth_host_pkg::*;
#(
	parameter int SCLK_HALF = SCLK_HALF_CYC
) (
	input  wire logic i_clk_sys,
	input  wire logic i_srst,
	input  wire cmd_s i_cmd,
	input  wire logic i_cmd_valid,
	input  wire logic i_align_mod,
	input  wire logic i_ref_clk,
	output logic      o_cmd_ready,
	output logic      o_phase_pending,
	output logic      o_sclk,
	output logic      o_sdata,
	output logic      o_le
);
	// Select code and word length per command
	function automatic logic [2:0] sel_of(input op_e op);
		case (op)
			OP_FREQ:   sel_of = SEL_FREQ;
			OP_MOD:    sel_of = SEL_MOD;
			OP_PHASE:  sel_of = SEL_PHASE;
			OP_FUNC:   sel_of = SEL_FUNC;
			OP_TIMERS: sel_of = SEL_TIMER;
			default:   sel_of = SEL_PDOWN;
		endcase
	endfunction

	function automatic logic [4:0] len_of(input op_e op);
		case (op)
			OP_FREQ:   len_of = LEN_FREQ;
			OP_MOD:    len_of = LEN_MOD;
			OP_PHASE:  len_of = LEN_PHASE;
			OP_FUNC:   len_of = LEN_FUNC;
			OP_TIMERS: len_of = LEN_TIMER;
			default:   len_of = LEN_PDOWN;
		endcase
	endfunction

	// Word assembly; reserved fields forced so the user cannot break them
	function automatic logic [WORD_W-1:0] build_word(input op_e op, input logic [20:0] d,
			input logic [1:0] tsel, input logic [8:0] cnt);
		case (op)
			OP_PHASE:  build_word = {8'h00, PHASE_RSV_VAL, d[11:0], sel_of(op)};
			OP_FUNC:   build_word = {8'h00, FUNC_RSV_VAL, d[1], FUNC_RSV4_VAL, d[0], sel_of(op)};
			OP_TIMERS: build_word = {TIMER_RSV_VAL, cnt, tsel, sel_of(op)};
			OP_PDOWN:  build_word = {16'h0000, d[4:0], sel_of(op)};
			default:   build_word = {d, sel_of(op)};
		endcase
	endfunction

	// Timer write order: boost, third switch, first and second switches
	function automatic logic [1:0] tsel_of(input logic [1:0] step);
		case (step)
			2'h0:    tsel_of = TSEL_BOOST;
			2'h1:    tsel_of = TSEL_SW3;
			default: tsel_of = TSEL_SW12;
		endcase
	endfunction

	state_e            st_reg, st_next;
	op_e               op_reg;
	logic [20:0]       data_reg;
	logic [WORD_W-1:0] sh_reg, sh_next;
	logic [4:0]        bits_reg, bits_next;
	logic [7:0]        div_reg, div_next;
	logic [1:0]        step_reg, step_next;
	logic [8:0]        boost_reg;
	logic [11:0]       mod_reg;
	logic [11:0]       ref_cnt_reg;
	logic              ref_s1_reg, ref_s2_reg, ref_s3_reg;
	logic              sclk_reg, sclk_next, le_reg, le_next;
	logic              ready_reg, ready_next, pend_reg, pend_next;

	// Command decode and word preparation
	wire logic              accept     = ready_reg & i_cmd_valid;
	wire logic [9:0]        sw_sum     = {1'b0, boost_reg} + {1'b0, SW_MARGIN};
	wire logic [8:0]        sw_cnt     = sw_sum[9] ? CNT_MAX : sw_sum[8:0];
	wire logic [WORD_W-1:0] word_new   = build_word(i_cmd.op, i_cmd.data, TSEL_BOOST, i_cmd.data[8:0]);
	wire logic [WORD_W-1:0] word_step  = build_word(op_reg, data_reg, tsel_of(step_next), sw_cnt);
	wire logic              div_done   = (div_reg == 8'h00);
	wire logic              ref_rise   = ref_s2_reg & ~ref_s3_reg;
	wire logic              ref_ok     = ref_rise & (~i_align_mod | (ref_cnt_reg == 12'h000));
	wire logic              last_bit   = (bits_reg == 5'h01);
	wire logic [7:0]        half_m1    = 8'(SCLK_HALF - 1);
	wire logic              latch_end  = (st_reg == ST_LATCH) & div_done;

	// Sequencer: shift on falling edge, device samples on rising
	always_comb begin
		st_next    = st_reg;
		sh_next    = sh_reg;
		bits_next  = bits_reg;
		div_next   = div_done ? half_m1 : div_reg - 8'h01;
		step_next  = step_reg;
		sclk_next  = sclk_reg;
		le_next    = le_reg;
		ready_next = ready_reg;
		pend_next  = pend_reg;
		case (st_reg)
			ST_IDLE: begin
				div_next = half_m1;
				if (accept) begin
					sh_next    = word_new << (5'(WORD_W) - len_of(i_cmd.op));
					bits_next  = len_of(i_cmd.op);
					step_next  = 2'h0;
					ready_next = 1'b0;
					st_next    = ST_SHIFT;
				end
			end
			ST_SHIFT: if (div_done) begin
				sclk_next = ~sclk_reg;
				if (sclk_reg) begin
					bits_next = bits_reg - 5'h01;
					sh_next   = sh_reg << 1;
					if (last_bit)
						st_next = (op_reg == OP_FREQ) ? ST_REFWT : ST_LATCH;
				end
			end
			ST_REFWT: begin
				div_next = half_m1;
				if (ref_ok) begin
					le_next = 1'b1;
					st_next = ST_LATCH;
				end
			end
			ST_LATCH: begin
				le_next = 1'b1;
				if (div_done) begin
					le_next = 1'b0;
					st_next = ST_GAP;
					if (op_reg == OP_PHASE)
						pend_next = 1'b1;
					else if (op_reg == OP_FREQ)
						pend_next = 1'b0;
				end
			end
			ST_GAP: if (div_done) begin
				if (op_reg == OP_TIMERS && step_reg != 2'h2) begin
					step_next = step_reg + 2'h1;
					sh_next   = word_step;
					bits_next = LEN_TIMER;
					st_next   = ST_SHIFT;
				end else begin
					ready_next = 1'b1;
					st_next    = ST_IDLE;
				end
			end
			default: st_next = ST_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			st_reg    <= ST_IDLE;
			sh_reg    <= '0;
			bits_reg  <= 5'h00;
			div_reg   <= 8'h00;
			step_reg  <= 2'h0;
			sclk_reg  <= 1'b0;
			le_reg    <= 1'b0;
			ready_reg <= 1'b1;
			pend_reg  <= 1'b0;
		end else begin
			st_reg    <= st_next;
			sh_reg    <= sh_next;
			bits_reg  <= bits_next;
			div_reg   <= div_next;
			step_reg  <= step_next;
			sclk_reg  <= sclk_next;
			le_reg    <= le_next;
			ready_reg <= ready_next;
			pend_reg  <= pend_next;
		end
	end

	// Captured command; modulus kept for frequency-write spacing
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			op_reg    <= OP_PDOWN;
			data_reg  <= '0;
			boost_reg <= 9'h000;
			mod_reg   <= MOD_RESET;
		end else if (accept) begin
			op_reg   <= i_cmd.op;
			data_reg <= i_cmd.data;
			if (i_cmd.op == OP_TIMERS)
				boost_reg <= i_cmd.data[8:0];
			if (i_cmd.op == OP_MOD)
				mod_reg <= i_cmd.data[11:0];
		end
	end

	// Reference synchroniser; runs through reset so no false edge follows it
	always_ff @(posedge i_clk_sys) begin
		ref_s1_reg <= i_ref_clk;
		ref_s2_reg <= ref_s1_reg;
		ref_s3_reg <= ref_s2_reg;
	end

	// Reference cycles modulo the modulus, so spaced loads repeat phase
	always_ff @(posedge i_clk_sys) begin
		if (i_srst)
			ref_cnt_reg <= 12'h000;
		else if (ref_rise)
			ref_cnt_reg <= (ref_cnt_reg + 12'h001 >= mod_reg) ? 12'h000 : ref_cnt_reg + 12'h001;
	end

	assign o_cmd_ready     = ready_reg;
	assign o_phase_pending = pend_reg;
	assign o_sclk          = sclk_reg;
	assign o_sdata         = sh_reg[WORD_W-1];
	assign o_le            = le_reg;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	sequence seq_last_fall;
		(st_reg == ST_SHIFT) && last_bit && sclk_reg && div_done;
	endsequence

	AST_SEL_PHASE: assert property (accept && i_cmd.op == OP_PHASE |-> word_new[2:0] == 3'h2 && !word_new[15])
		else $error("phase word select or top bit wrong");
	AST_FUNC_RSV: assert property (accept && i_cmd.op == OP_FUNC |-> word_new[15:6] == 10'h001 && word_new[4])
		else $error("function reserved bits wrong");
	AST_TIMER_RSV: assert property (accept && i_cmd.op == OP_TIMERS |-> word_new[23:14] == 10'h001)
		else $error("timer reserved bits wrong");
	AST_FREQ_REF: assert property ($rose(o_le) && op_reg == OP_FREQ |-> $past(ref_rise))
		else $error("frequency load not aligned to reference edge");
	AST_FREQ_MOD: assert property ($rose(o_le) && op_reg == OP_FREQ && $past(i_align_mod) |-> $past(ref_cnt_reg) == 12'h000)
		else $error("frequency load not on modulus boundary");
	AST_PEND_SET: assert property (latch_end && op_reg == OP_PHASE |=> o_phase_pending)
		else $error("phase pending not raised");
	AST_PEND_CLR: assert property (latch_end && op_reg == OP_FREQ |=> !o_phase_pending)
		else $error("phase pending not cleared");
	AST_DATA_STABLE: assert property (o_sclk |-> $stable(o_sdata) && !o_le)
		else $error("data moved while serial clock high");
	AST_LE_AFTER: assert property (seq_last_fall |=> !o_sclk ##1 !o_sclk)
		else $error("serial clock toggled after last bit");
	AST_SW_CNT: assert property (st_reg == ST_GAP && div_done && op_reg == OP_TIMERS && step_reg != 2'h2
			|=> sh_reg[13:5] == ((boost_reg > CNT_MAX - SW_MARGIN) ? CNT_MAX : boost_reg + SW_MARGIN)
			&& sh_reg[4:3] == ((step_reg == 2'h1) ? TSEL_SW3 : TSEL_SW12))
		else $error("switch timer word wrong");
endmodule

// *** tb/synth_device_model.sv ***
// Behavioural synthesizer serial port and write-only register file
`timescale 1ns/10ps
module synth_device_model (
	input  wire logic        i_sclk,
	input  wire logic        i_sdata,
	input  wire logic        i_le,
	output logic      [23:0] o_word,
	output logic      [4:0]  o_len,
	output logic      [15:0] o_count
);
	logic [23:0] shift_reg = 24'h000000;
	logic [4:0]  nbits_reg = 5'h00;
	logic [11:0] phase_buf_reg;
	logic [11:0] phase_seed_reg;
	logic [5:0]  func_reg;
	logic [4:0]  pdown_reg;
	logic [8:0]  tmr_reg [0:2];
	logic [8:0]  tmr_run_reg [0:2];
	initial o_count = 16'h0000;
	// Bits taken on the rising serial clock, first bit ends up on top
	always @(posedge i_sclk) begin
		shift_reg = {shift_reg[22:0], i_sdata};
		nbits_reg = nbits_reg + 5'h01;
	end
	// Load strobe routes the word by its three select bits
	always @(posedge i_le) begin
		case (shift_reg[2:0])
			3'h2: phase_buf_reg = shift_reg[14:3];
			3'h3: func_reg = shift_reg[8:3];
			3'h4: if (shift_reg[4:3] != 2'h3) tmr_reg[shift_reg[4:3]] = shift_reg[13:5];
			3'h5: pdown_reg = shift_reg[7:3];
			3'h0: begin
				phase_seed_reg = phase_buf_reg;
				for (int i = 0; i < 3; i++) tmr_run_reg[i] = tmr_reg[i];
			end
			default: ;
		endcase
		o_word = shift_reg;
		o_len = nbits_reg;
		// Cleared so a short word never carries bits of the last long one
		shift_reg = 24'h000000;
		nbits_reg = 5'h00;
		o_count = o_count + 16'h0001;
	end
endmodule

// *** tb/test_synth_phase_function_fastlock_regs.sv ***
// Self-checking bench for the synthesizer serial-load controller
`timescale 1ns/10ps
module test_synth_phase_function_fastlock_regs
	import synth_host_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        srst    = 1'b1;
	logic        vld     = 1'b0;
	logic        align   = 1'b0;
	logic        ref_clk = 1'b0;
	cmd_s        cmd     = '{OP_PDOWN, 21'h000000};
	wire         ready;
	wire         pending;
	wire         sclk;
	wire         sdata;
	wire         le;
	wire  [23:0] m_word;
	wire  [4:0]  m_len;
	wire  [15:0] m_count;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          seed = 32'h89B8;
	logic [28:0] exp_q [$];
	logic [8:0]  tcnt [5] = '{9'h000, 9'h01C, 9'h1F8, 9'h1F9, 9'h1FF};

	// Clocks; the reference runs free with no phase tie to the system clock
	always #2.5 clk_sys = ~clk_sys;
	always #24 ref_clk = ~ref_clk;

	synth_phase_function_fastlock_regs #(.SCLK_HALF(2)) dut_u (
		.i_clk_sys(clk_sys), .i_srst(srst), .i_cmd(cmd), .i_cmd_valid(vld), .i_align_mod(align),
		.i_ref_clk(ref_clk), .o_cmd_ready(ready), .o_phase_pending(pending), .o_sclk(sclk),
		.o_sdata(sdata), .o_le(le));
	synth_device_model mdl_u (.i_sclk(sclk), .i_sdata(sdata), .i_le(le), .o_word(m_word), .o_len(m_len),
		.o_count(m_count));

	task automatic check(input logic [28:0] seen, input logic [28:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Notes the expected word(s), issues one command, optionally pokes while busy
	task automatic send(input op_e op, input logic [20:0] d, input logic poke);
		logic [9:0] s;
		logic [8:0] c7;
		int         k;
		s = {1'b0, d[8:0]} + 10'h007;
		c7 = s[9] ? CNT_MAX : s[8:0];
		case (op)
			OP_FREQ: exp_q.push_back({LEN_FREQ, d, SEL_FREQ});
			OP_MOD: exp_q.push_back({LEN_MOD, d, SEL_MOD});
			OP_PHASE: exp_q.push_back({LEN_PHASE, 8'h00, PHASE_RSV_VAL, d[11:0], SEL_PHASE});
			OP_FUNC: exp_q.push_back({LEN_FUNC, 8'h00, FUNC_RSV_VAL, d[1], FUNC_RSV4_VAL, d[0], SEL_FUNC});
			OP_TIMERS: begin
				exp_q.push_back({LEN_TIMER, TIMER_RSV_VAL, d[8:0], TSEL_BOOST, SEL_TIMER});
				exp_q.push_back({LEN_TIMER, TIMER_RSV_VAL, c7, TSEL_SW3, SEL_TIMER});
				exp_q.push_back({LEN_TIMER, TIMER_RSV_VAL, c7, TSEL_SW12, SEL_TIMER});
			end
			default: exp_q.push_back({LEN_PDOWN, 16'h0000, d[4:0], SEL_PDOWN});
		endcase
		cmd <= '{op, d};
		vld <= 1'b1;
		do @(posedge clk_sys); while (ready !== 1'b1);
		vld <= 1'b0;
		@(posedge clk_sys);
		// A request while busy must be dropped, not queued
		if (poke) begin
			vld <= 1'b1;
			@(posedge clk_sys);
			vld <= 1'b0;
		end
		k = 0;
		while (ready !== 1'b1 && k < 4000) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 4000) n_errors++;
	endtask

	// Each latched word is matched against the oldest note; armed after reset, past the model's power-up count
	initial begin
		@(negedge srst);
		forever begin
			@(m_count);
			if (exp_q.size() == 0) n_errors++;
			else check({m_len, m_word}, exp_q.pop_front());
		end
	end

	initial begin
		#100000;
		n_errors++;
		final_report();
	end

	initial begin
		logic [20:0] r;
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		// Bring-up order: power-down, phase, modulus, frequency
		r = 21'($random(seed));
		send(OP_PDOWN, r, 1'b0);
		r = 21'($random(seed));
		send(OP_PHASE, r, 1'b0);
		check(29'(pending), 29'h1);
		r = 21'($random(seed));
		send(OP_MOD, {r[20:12], 12'h00D}, 1'b0);
		check(29'(pending), 29'h1);
		r = 21'($random(seed));
		send(OP_FREQ, r, 1'b1);
		check(29'(pending), 29'h0);
		// Every clamp and polarity combination
		for (int i = 0; i < 4; i++) send(OP_FUNC, 21'(i), 1'b0);
		// Counts at both ends, including the saturating margin
		for (int i = 0; i < 5; i++) send(OP_TIMERS, {12'h000, tcnt[i]}, 1'b0);
		r = 21'($random(seed));
		send(OP_TIMERS, r, 1'b1);
		// Back-to-back frequency writes with alignment on and off
		for (int i = 0; i < 6; i++) begin
			align <= i[0];
			r = 21'($random(seed));
			send(OP_FREQ, r, 1'b0);
		end
		repeat (200) @(posedge clk_sys);
		check(29'(exp_q.size()), 29'h0);
		final_report();
	end
endmodule
